// ---- design/audio_serial_input_router.sv ----
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`include "audio_router_map.svh"
module audio_serial_input_router #(
  parameter int unsigned LOSS_CYCLES = `LOSS_TIME_NS / `CLK_PERIOD_NS,
  parameter logic [4:0]  ADDR_BASE   = 5'h0A
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rstn,
  input  wire logic [7:0]           i_addr,
  input  wire logic [31:0]          i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic      [31:0]          o_rdata,
  input  wire logic                 i_port_a_bit_clock,
  input  wire logic                 i_port_a_word_select,
  input  wire logic                 i_port_a_serial_in,
  input  wire logic                 i_port_b_bit_clock,
  input  wire logic                 i_port_b_word_select,
  input  wire logic                 i_port_b_serial_in,
  input  wire logic                 i_aux_stereo_serial_in,
  input  wire logic                 i_bus_addr_strap_lo,
  input  wire logic                 i_bus_addr_strap_hi,
  output logic                      o_serial_audio_out,
  output logic                      o_serial_audio_out_oe,
  output logic      [`WORD_W-1:0]   o_primary_left,
  output logic      [`WORD_W-1:0]   o_primary_right,
  output logic                      o_primary_valid,
  output logic      [`WORD_W-1:0]   o_aux_left,
  output logic      [`WORD_W-1:0]   o_aux_right,
  output logic                      o_ref_tick,
  output logic      [6:0]           o_bus_slave_addr,
  output logic                      o_amp_enable
);
  localparam int W  = `WORD_W;
  localparam int LW = $clog2(LOSS_CYCLES + 1);
  ////////////////////////////////////////////////////////////////////////////
  logic [`CTRL_W-1:0]          ctrl_ff;
  logic [W-1:0]                proc_ff;
  logic [W-1:0]                cur_ff;
  logic [W-1:0]                gain_ff;
  audio_router_pkg::tx_words_t hold_ff;
  logic                        pend_ff;
  logic                        req_ff;
  logic [15:0]                 frame_cnt_ff;
  audio_router_pkg::ratio_t    ratio_a_ff;
  audio_router_pkg::ratio_t    ratio_b_ff;
  logic [1:0]                  present_ff;
  logic [LW-1:0]               loss_cnt_ff [2];
  logic [5:0]                  prev_ff;
  audio_router_pkg::strap_state_t strap_st_ff;
  logic [2:0]                  settle_ff;
  audio_router_pkg::cfg_t      cfg;
  audio_router_pkg::rx_words_t rx_a;
  audio_router_pkg::rx_words_t rx_b;
  audio_router_pkg::rx_words_t rx_sel;
  logic [5:0]                  link_s;
  logic [1:0]                  strap_s;
  logic                        fr_a_tgl;
  logic                        fr_b_tgl;
  logic                        bit_a_tgl;
  logic                        bit_b_tgl;
  logic                        ack_a;
  logic                        ack_b;
  logic                        sdo_a;
  logic                        sdo_b;
  logic                        oe_a;
  logic                        oe_b;
  logic                        choice;
  logic                        fr_a_e;
  logic                        fr_b_e;
  logic                        bit_a_e;
  logic                        bit_b_e;
  logic                        sel_fr_e;
  logic                        sel_bit_e;
  logic                        ack_sel;
  logic                        data_wr;
  logic [31:0]                 nxt_rdata;
  logic [31:0]                 status;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // choice bit picks the active port
  assign choice = ctrl_ff[`CTRL_CHOICE];
  assign cfg.out_en    = ctrl_ff[`CTRL_OUT_EN];
  assign cfg.pass_en   = ctrl_ff[`CTRL_PASS_EN];
  assign cfg.pass_src  = audio_router_pkg::pass_src_t'(ctrl_ff[`CTRL_PASS_SRC +: 2]);
  assign cfg.payload   = audio_router_pkg::payload_t'(ctrl_ff[`CTRL_PAYLOAD +: 2]);
  assign cfg.aux_right = ctrl_ff[`CTRL_AUX_RIGHT];

  // each port runs on its own host clocks
  audio_link_port #(.IS_B(1'b0)) u_port_a (
    .i_bck      (i_port_a_bit_clock),
    .i_rstn     (i_rstn),
    .i_ws       (i_port_a_word_select),
    .i_din      (i_port_a_serial_in),
    .i_din_other(i_port_b_serial_in),
    .i_aux      (i_aux_stereo_serial_in),
    .i_active   (~choice),
    .i_cfg      (cfg),
    .i_tx       (hold_ff),
    .i_tx_req   (req_ff),
    .o_tx_ack   (ack_a),
    .o_rx       (rx_a),
    .o_frame_tgl(fr_a_tgl),
    .o_bit_tgl  (bit_a_tgl),
    .o_sdo      (sdo_a),
    .o_sdo_oe   (oe_a)
  );
  audio_link_port #(.IS_B(1'b1)) u_port_b (
    .i_bck      (i_port_b_bit_clock),
    .i_rstn     (i_rstn),
    .i_ws       (i_port_b_word_select),
    .i_din      (i_port_b_serial_in),
    .i_din_other(i_port_a_serial_in),
    .i_aux      (i_aux_stereo_serial_in),
    .i_active   (choice),
    .i_cfg      (cfg),
    .i_tx       (hold_ff),
    .i_tx_req   (req_ff),
    .o_tx_ack   (ack_b),
    .o_rx       (rx_b),
    .o_frame_tgl(fr_b_tgl),
    .o_bit_tgl  (bit_b_tgl),
    .o_sdo      (sdo_b),
    .o_sdo_oe   (oe_b)
  );

  // Mux by choice: a port whose clock stopped keeps its last flop values
  assign o_serial_audio_out    = choice ? sdo_b : sdo_a;
  assign o_serial_audio_out_oe = choice ? oe_b : oe_a;

  sync2 #(.W(6)) u_sync_link (
    .i_clk (i_clk),
    .i_rstn(i_rstn),
    .i_d   ({fr_a_tgl, fr_b_tgl, bit_a_tgl, bit_b_tgl, ack_a, ack_b}),
    .o_q   (link_s)
  );
  sync2 #(.W(2)) u_sync_strap (
    .i_clk (i_clk),
    .i_rstn(i_rstn),
    .i_d   ({i_bus_addr_strap_hi, i_bus_addr_strap_lo}),
    .o_q   (strap_s)
  );

  assign fr_a_e  = link_s[5] ^ prev_ff[5];
  assign fr_b_e  = link_s[4] ^ prev_ff[4];
  assign bit_a_e = link_s[3] ^ prev_ff[3];
  assign bit_b_e = link_s[2] ^ prev_ff[2];
  assign sel_fr_e  = choice ? fr_b_e : fr_a_e;
  assign sel_bit_e = choice ? bit_b_e : bit_a_e;
  assign ack_sel   = choice ? link_s[0] : link_s[1];
  assign rx_sel    = choice ? rx_b : rx_a;
  assign data_wr   = i_wr & (hit(i_addr, `OFF_PROC_AUDIO) | hit(i_addr, `OFF_AMP_CUR) |
                             hit(i_addr, `OFF_GAIN_INFO));

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) prev_ff <= 6'h00;
    else prev_ff <= link_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // choice frozen while amplifier is on
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_ff <= `CTRL_RST;
    end else if (i_wr && hit(i_addr, `OFF_CTRL)) begin
      ctrl_ff <= i_wdata[`CTRL_W-1:0];
      if (ctrl_ff[`CTRL_AMP_ON]) ctrl_ff[`CTRL_CHOICE] <= ctrl_ff[`CTRL_CHOICE];
    end
  end

  // proc, current and gain words held for the paired amplifier
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      proc_ff <= {W{1'b0}};
      cur_ff  <= {W{1'b0}};
      gain_ff <= {W{1'b0}};
    end else if (i_wr) begin
      if (hit(i_addr, `OFF_PROC_AUDIO)) proc_ff <= i_wdata[W-1:0];
      if (hit(i_addr, `OFF_AMP_CUR)) cur_ff <= i_wdata[W-1:0];
      if (hit(i_addr, `OFF_GAIN_INFO)) gain_ff <= i_wdata[W-1:0];
    end
  end

  // Hold words stay still until the link acks, so they cross safely
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hold_ff <= '0;
      req_ff  <= 1'b0;
      pend_ff <= 1'b0;
    end else begin
      if (pend_ff && (req_ff == ack_sel)) begin
        hold_ff <= '{proc_w: proc_ff, cur_w: cur_ff, gain_w: gain_ff};
        req_ff  <= ~req_ff;
      end
      // A write in the launch cycle keeps the request pending
      if (data_wr) pend_ff <= 1'b1;
      else if (pend_ff && (req_ff == ack_sel)) pend_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // selected port words go to playback
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_primary_left  <= {W{1'b0}};
      o_primary_right <= {W{1'b0}};
      o_primary_valid <= 1'b0;
      frame_cnt_ff    <= 16'h0000;
    end else begin
      o_primary_valid <= sel_fr_e & present_ff[choice];
      if (sel_fr_e) begin
        o_primary_left  <= rx_sel.prim_l;
        o_primary_right <= rx_sel.prim_r;
        frame_cnt_ff    <= frame_cnt_ff + 16'h0001;
      end
    end
  end

  // auxiliary stream kept apart from playback
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_aux_left  <= {W{1'b0}};
      o_aux_right <= {W{1'b0}};
    end else if (sel_fr_e) begin
      o_aux_left  <= rx_sel.aux_l;
      o_aux_right <= rx_sel.aux_r;
    end
  end

  // reference tick from word select or bit clock
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) o_ref_tick <= 1'b0;
    else o_ref_tick <= ctrl_ff[`CTRL_REF_BCK] ? sel_bit_e : sel_fr_e;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ratio_a_ff <= audio_router_pkg::RATIO_NONE;
      ratio_b_ff <= audio_router_pkg::RATIO_NONE;
    end else begin
      if (fr_a_e) ratio_a_ff <= rx_a.ratio;
      else if (!present_ff[0]) ratio_a_ff <= audio_router_pkg::RATIO_NONE;
      if (fr_b_e) ratio_b_ff <= rx_b.ratio;
      else if (!present_ff[1]) ratio_b_ff <= audio_router_pkg::RATIO_NONE;
    end
  end

  // Clock loss watchdog; a stopped port cannot play
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      loss_cnt_ff[0] <= LW'(LOSS_CYCLES);
      loss_cnt_ff[1] <= LW'(LOSS_CYCLES);
      present_ff     <= 2'h0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if ((p == 0) ? fr_a_e : fr_b_e) begin
          loss_cnt_ff[p] <= {LW{1'b0}};
          present_ff[p]  <= 1'b1;
        end else if (loss_cnt_ff[p] != LW'(LOSS_CYCLES)) begin
          loss_cnt_ff[p] <= loss_cnt_ff[p] + LW'(1);
        end else begin
          present_ff[p] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) o_amp_enable <= 1'b0;
    else o_amp_enable <= ctrl_ff[`CTRL_AMP_ON] & present_ff[choice];
  end

  ////////////////////////////////////////////////////////////////////////////
  // straps caught once after reset
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      strap_st_ff      <= audio_router_pkg::SS_SETTLE;
      settle_ff        <= 3'h0;
      o_bus_slave_addr <= 7'h00;
    end else begin
      unique case (strap_st_ff)
        audio_router_pkg::SS_SETTLE: begin
          if (settle_ff == `STRAP_SETTLE) begin
            o_bus_slave_addr <= {ADDR_BASE, strap_s};
            strap_st_ff      <= audio_router_pkg::SS_LATCHED;
          end else begin
            settle_ff <= settle_ff + 3'h1;
          end
        end
        audio_router_pkg::SS_LATCHED: begin
          strap_st_ff <= audio_router_pkg::SS_LATCHED;
        end
        default: strap_st_ff <= audio_router_pkg::SS_SETTLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    status = 32'h0000_0000;
    status[`ST_RATIO_A +: 2]    = ratio_a_ff;
    status[`ST_RATIO_B +: 2]    = ratio_b_ff;
    status[`ST_PRESENT_A]       = present_ff[0];
    status[`ST_PRESENT_B]       = present_ff[1];
    status[`ST_SLAVE_ADDR +: 7] = o_bus_slave_addr;
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (hit(i_addr, `OFF_CTRL)) nxt_rdata[`CTRL_W-1:0] = ctrl_ff;
    if (hit(i_addr, `OFF_STATUS)) nxt_rdata = status;
    if (hit(i_addr, `OFF_PROC_AUDIO)) nxt_rdata[W-1:0] = proc_ff;
    if (hit(i_addr, `OFF_AMP_CUR)) nxt_rdata[W-1:0] = cur_ff;
    if (hit(i_addr, `OFF_GAIN_INFO)) nxt_rdata[W-1:0] = gain_ff;
    if (hit(i_addr, `OFF_PRIM_LEFT)) nxt_rdata[W-1:0] = o_primary_left;
    if (hit(i_addr, `OFF_PRIM_RIGHT)) nxt_rdata[W-1:0] = o_primary_right;
    if (hit(i_addr, `OFF_AUX_LEFT)) nxt_rdata[W-1:0] = o_aux_left;
    if (hit(i_addr, `OFF_AUX_RIGHT)) nxt_rdata[W-1:0] = o_aux_right;
    if (hit(i_addr, `OFF_FRAME_CNT)) nxt_rdata[15:0] = frame_cnt_ff;
  end

  // Read data stands only in the cycle after each cycle with i_rd high; zero otherwise
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) o_rdata <= 32'h0000_0000;
    else o_rdata <= i_rd ? nxt_rdata : 32'h0000_0000;
  end
endmodule

// ---- design/audio_router_map.svh ----
`ifndef AUDIO_ROUTER_MAP_SVH
`define AUDIO_ROUTER_MAP_SVH
`define WORD_W         24
`define OFF_CTRL       8'h00
`define OFF_STATUS     8'h04
`define OFF_PROC_AUDIO 8'h08
`define OFF_AMP_CUR    8'h0C
`define OFF_GAIN_INFO  8'h10
`define OFF_PRIM_LEFT  8'h14
`define OFF_PRIM_RIGHT 8'h18
`define OFF_AUX_LEFT   8'h1C
`define OFF_AUX_RIGHT  8'h20
`define OFF_FRAME_CNT  8'h24
`define CTRL_CHOICE    0
`define CTRL_OUT_EN    1
`define CTRL_PASS_EN   2
`define CTRL_PASS_SRC  3
`define CTRL_PAYLOAD   5
`define CTRL_AUX_RIGHT 7
`define CTRL_REF_BCK   8
`define CTRL_AMP_ON    9
`define CTRL_W         10
`define CTRL_RST       10'h000
`define ST_RATIO_A     0
`define ST_RATIO_B     2
`define ST_PRESENT_A   4
`define ST_PRESENT_B   5
`define ST_SLAVE_ADDR  8
`define HALF_X32       6'h10
`define HALF_X48       6'h18
`define HALF_X64       6'h20
`define STRAP_SETTLE   3'h3
`define CLK_PERIOD_NS  8
`define LOSS_TIME_NS   250000
`endif

// ---- design/audio_router_pkg.sv ----
`include "audio_router_map.svh"
package audio_router_pkg;
  typedef enum logic [1:0] {
    PL_PROC = 2'h0, PL_CURRENT = 2'h1, PL_AUX = 2'h2, PL_GAIN = 2'h3
  } payload_t;
  typedef enum logic [1:0] {
    PS_A = 2'h0, PS_B = 2'h1, PS_AUX = 2'h2, PS_AUX_ALT = 2'h3
  } pass_src_t;
  typedef enum logic [1:0] {
    RATIO_NONE = 2'h0, RATIO_X32 = 2'h1, RATIO_X48 = 2'h2, RATIO_X64 = 2'h3
  } ratio_t;
  typedef enum logic [1:0] {
    SS_SETTLE = 2'h1, SS_LATCHED = 2'h2
  } strap_state_t;
  typedef struct packed {
    logic      out_en;
    logic      pass_en;
    pass_src_t pass_src;
    payload_t  payload;
    logic      aux_right;
  } cfg_t;
  typedef struct packed {
    logic [`WORD_W-1:0] proc_w;
    logic [`WORD_W-1:0] cur_w;
    logic [`WORD_W-1:0] gain_w;
  } tx_words_t;
  typedef struct packed {
    logic [`WORD_W-1:0] prim_l;
    logic [`WORD_W-1:0] prim_r;
    logic [`WORD_W-1:0] aux_l;
    logic [`WORD_W-1:0] aux_r;
    ratio_t             ratio;
  } rx_words_t;
endpackage

// ---- design/sync2.sv ----
`timescale 1ns/100ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  // First stage feeds only the second
  logic [W-1:0] meta_ff;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_ff <= {W{1'b0}};
      o_q     <= {W{1'b0}};
    end else begin
      meta_ff <= i_d;
      o_q     <= meta_ff;
    end
  end
endmodule

// ---- design/audio_link_port.sv ----
`timescale 1ns/100ps
`include "audio_router_map.svh"
module audio_link_port #(
  parameter bit IS_B = 1'b0
) (
  input  wire logic                        i_bck,
  input  wire logic                        i_rstn,
  input  wire logic                        i_ws,
  input  wire logic                        i_din,
  input  wire logic                        i_din_other,
  input  wire logic                        i_aux,
  input  wire logic                        i_active,
  input  wire audio_router_pkg::cfg_t      i_cfg,
  input  wire audio_router_pkg::tx_words_t i_tx,
  input  wire logic                        i_tx_req,
  output logic                             o_tx_ack,
  output audio_router_pkg::rx_words_t      o_rx,
  output logic                             o_frame_tgl,
  output logic                             o_bit_tgl,
  output logic                             o_sdo,
  output logic                             o_sdo_oe
);
  localparam int W = `WORD_W;
  localparam int CW = $bits(audio_router_pkg::cfg_t);
  logic [CW+1:0] xin_q;
  logic [CW:0]   cfg_prev_ff;
  logic active_s, req_s, act_cur_ff, ws_ff, pass_ff, edge_w, take, frame_start, cfg_ok;
  audio_router_pkg::cfg_t cfg_s, cfg_cur_ff, cfg_use;
  audio_router_pkg::tx_words_t tx_cur_ff;
  logic [5:0] pos_ff, half_len;
  logic [W-1:0] sh_ff, aux_sh_ff, left_ff, aux_left_ff, word_al, aux_al, tx_sh_ff, tx_word;
  sync2 #(.W(CW + 2)) u_sync (
    .i_clk (i_bck),
    .i_rstn(i_rstn),
    .i_d   ({i_active, i_tx_req, i_cfg}),
    .o_q   (xin_q)
  );
  assign {active_s, req_s, cfg_s} = xin_q;
  function automatic logic [W-1:0] align(input logic [W-1:0] w, input logic [5:0] n);
    align = (n < 6'(W)) ? (w << (6'(W) - n)) : w;
  endfunction
  assign edge_w      = i_ws ^ ws_ff;
  assign take        = pos_ff < 6'(W);
  assign half_len    = pos_ff + 6'h01;
  assign frame_start = edge_w & ws_ff;
  assign cfg_ok      = frame_start & ({active_s, cfg_s} == cfg_prev_ff);
  assign word_al = align(take ? {sh_ff[W-2:0], i_din} : sh_ff, half_len);
  assign aux_al  = align(take ? {aux_sh_ff[W-2:0], i_aux} : aux_sh_ff, half_len);
  assign cfg_use = cfg_ok ? cfg_s : cfg_cur_ff;
  always_comb begin
    unique case (cfg_use.payload)
      audio_router_pkg::PL_PROC:    tx_word = tx_cur_ff.proc_w;
      audio_router_pkg::PL_CURRENT: tx_word = tx_cur_ff.cur_w;
      audio_router_pkg::PL_AUX:     tx_word = cfg_use.aux_right ? o_rx.aux_r : o_rx.aux_l;
      audio_router_pkg::PL_GAIN:    tx_word = tx_cur_ff.gain_w;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_bck or negedge i_rstn) begin
    if (!i_rstn) begin
      ws_ff <= 1'b0; pos_ff <= 6'h00; o_bit_tgl <= 1'b0;
      sh_ff <= {W{1'b0}}; aux_sh_ff <= {W{1'b0}};
    end else begin
      ws_ff     <= i_ws;
      o_bit_tgl <= ~o_bit_tgl;
      if (take) begin
        sh_ff     <= {sh_ff[W-2:0], i_din};
        aux_sh_ff <= {aux_sh_ff[W-2:0], i_aux};
      end
      if (edge_w) pos_ff <= 6'h00;
      else if (pos_ff != 6'h3F) pos_ff <= pos_ff + 6'h01;
    end
  end
  always_ff @(posedge i_bck or negedge i_rstn) begin
    if (!i_rstn) begin
      left_ff <= {W{1'b0}}; aux_left_ff <= {W{1'b0}};
      o_rx <= '0; o_frame_tgl <= 1'b0;
    end else if (edge_w && !ws_ff) begin
      left_ff     <= word_al;
      aux_left_ff <= aux_al;
    end else if (edge_w) begin
      o_rx.prim_l <= left_ff;
      o_rx.prim_r <= word_al;
      o_rx.aux_l  <= aux_left_ff;
      o_rx.aux_r  <= aux_al;
      o_rx.ratio  <= (half_len == `HALF_X32) ? audio_router_pkg::RATIO_X32 :
                     (half_len == `HALF_X48) ? audio_router_pkg::RATIO_X48 :
                     (half_len == `HALF_X64) ? audio_router_pkg::RATIO_X64 :
                                               audio_router_pkg::RATIO_NONE;
      o_frame_tgl <= ~o_frame_tgl;
    end
  end
  // frame start only; two equal samples avoid a half-synced word
  always_ff @(posedge i_bck or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_cur_ff <= '0; act_cur_ff <= 1'b0; cfg_prev_ff <= '0;
    end else begin
      cfg_prev_ff <= {active_s, cfg_s};
      if (cfg_ok) begin
        cfg_cur_ff <= cfg_s; act_cur_ff <= active_s;
      end
    end
  end
  // Word handshake: core holds i_tx until ack returns
  always_ff @(posedge i_bck or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_cur_ff <= '0; o_tx_ack <= 1'b0;
    end else if (req_s != o_tx_ack) begin
      tx_cur_ff <= i_tx; o_tx_ack <= req_s;
    end
  end
  // payload word loaded at each half frame
  always_ff @(posedge i_bck or negedge i_rstn) begin
    if (!i_rstn) tx_sh_ff <= {W{1'b0}};
    else if (edge_w) tx_sh_ff <= tx_word;
    else tx_sh_ff <= tx_sh_ff << 1;
  end
  // pass-through source, retimed by one bit
  always_ff @(posedge i_bck or negedge i_rstn) begin
    if (!i_rstn) pass_ff <= 1'b0;
    else unique case (cfg_cur_ff.pass_src)
      audio_router_pkg::PS_A: pass_ff <= IS_B ? i_din_other : i_din;
      audio_router_pkg::PS_B: pass_ff <= IS_B ? i_din : i_din_other;
      audio_router_pkg::PS_AUX, audio_router_pkg::PS_AUX_ALT: pass_ff <= i_aux;
    endcase
  end
  always_ff @(negedge i_bck or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sdo <= 1'b0; o_sdo_oe <= 1'b0;
    end else begin
      o_sdo_oe <= act_cur_ff & cfg_cur_ff.out_en;
      o_sdo    <= act_cur_ff & cfg_cur_ff.out_en &
                  (cfg_cur_ff.pass_en ? pass_ff : tx_sh_ff[W-1]);
    end
  end
endmodule

// ---- verification/router_checker.sv ----
`timescale 1ns/100ps
module router_checker #(
  parameter logic [4:0] ADDR_BASE = 5'h0A
) (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic [7:0]  i_addr,
  input  wire logic        i_rd,
  input  wire logic [31:0] o_rdata,
  input  wire logic        i_bus_addr_strap_lo,
  input  wire logic        i_bus_addr_strap_hi,
  input  wire logic [6:0]  o_bus_slave_addr,
  input  wire logic        o_primary_valid,
  input  wire logic        o_ref_tick
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  ////////////////////////////////////////////////////////////////////////////////
  a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside a read");
  a_unmapped_read: assert property ($past(i_rd) && $past(i_addr) >= 8'h28 |-> o_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_upper_zero: assert property ($past(i_rd) && $past(i_addr) == 8'h00 |-> o_rdata[31:10] == 22'h0)
    else $error("control upper bits set");
  a_status_addr: assert property ($past(i_rd) && $past(i_addr) == 8'h04 && $stable(o_bus_slave_addr)
    |-> o_rdata[31:8] == {17'h0, o_bus_slave_addr})
    else $error("status slave address mismatch");
  a_addr_straps: assert property (o_bus_slave_addr != 7'h00
    |-> o_bus_slave_addr == {ADDR_BASE, i_bus_addr_strap_hi, i_bus_addr_strap_lo})
    else $error("slave address not from straps");
  a_addr_held: assert property ($past(o_bus_slave_addr) != 7'h00 |-> $stable(o_bus_slave_addr))
    else $error("slave address changed");
  a_valid_pulse: assert property (o_primary_valid |=> !o_primary_valid)
    else $error("frame valid longer than one cycle");
  a_tick_pulse: assert property (o_ref_tick |=> !o_ref_tick)
    else $error("reference tick longer than one cycle");
endmodule
bind audio_serial_input_router router_checker #(.ADDR_BASE(ADDR_BASE)) i_chk (.i_clk(i_clk),
  .i_rstn(i_rstn), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_bus_addr_strap_lo(i_bus_addr_strap_lo), .i_bus_addr_strap_hi(i_bus_addr_strap_hi),
  .o_bus_slave_addr(o_bus_slave_addr), .o_primary_valid(o_primary_valid), .o_ref_tick(o_ref_tick));

// ---- verification/i2s_host_model.sv ----
`timescale 1ns/100ps
module i2s_host_model #(
  parameter int HALF = 32
) (
  input  wire logic        i_run,
  input  wire logic [23:0] i_left,
  input  wire logic [23:0] i_right,
  input  wire logic [23:0] i_aux,
  input  wire logic        i_sdo,
  output logic             o_bck,
  output logic             o_ws,
  output logic             o_dat,
  output logic             o_aux_dat,
  output logic      [23:0] o_rx
);
  logic [23:0] w;
  logic        cy;
  logic        ca;
  initial begin
    {o_bck, o_ws, o_dat, o_aux_dat, cy, ca} = 6'h10;
    o_rx = 24'h0;
    // Two rising edges so the link domain sees reset
    repeat (4) #16 o_bck = ~o_bck;
    forever begin
      if (!i_run) begin
        // Clock stands still; line toggles so no stale bit is seen
        #16 o_dat = ~o_dat;
      end else begin
        // own bit clock and word select frame this line
        for (int h = 0; h < 2; h++) begin
          w = h ? i_right : i_left;
          for (int i = 0; i < HALF; i++) begin
            o_ws = h[0];
            o_dat = i == 0 ? cy : (i < 25 ? w[24-i] : 1'b0);
            o_aux_dat = i == 0 ? ca : (i < 25 ? i_aux[24-i] : 1'b0);
            #16 o_bck = 1'b1;
            if (h == 0 && i > 0 && i < 25) o_rx[24-i] = i_sdo;
            #16 o_bck = 1'b0;
          end
          // First unsent bit of a short word spills into the next half's first slot
          cy = HALF < 25 ? w[24-HALF] : 1'b0;
          ca = HALF < 25 ? i_aux[24-HALF] : 1'b0;
        end
      end
    end
  end
endmodule

// ---- verification/tb_audio_serial_input_router.sv ----
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module tb_audio_serial_input_router;
  logic        i_clk = 1'b0;
  logic        i_rstn = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        run_a = 1'b0;
  logic        run_b = 1'b0;
  logic [31:0] d;
  logic [23:0] rx;
  logic [23:0] exp_w [4];
  logic [23:0] hv [6] = '{24'h123456, 24'h654321, 24'h0F1E2D, 24'hBEEF00, 24'hCAFE00, 24'h0};
  logic [1:0]  strap = 2'h2;
  int          fail_count = 0;
  int          n_tests = 0;
  wire         bck_a, ws_a, dat_a, aux, bck_b, ws_b, dat_b, sdo, oe, pv, amp;
  wire  [23:0] pl, pr, al, ar;
  wire  [31:0] d_w;
  wire         sdo_w = oe ? sdo : 1'bz;
  always #4 i_clk = ~i_clk;
  // Loss window kept above one 64x frame
  audio_serial_input_router #(.LOSS_CYCLES(1000)) i_dut (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(d_w),
    .i_port_a_bit_clock(bck_a), .i_port_a_word_select(ws_a), .i_port_a_serial_in(dat_a),
    .i_port_b_bit_clock(bck_b), .i_port_b_word_select(ws_b), .i_port_b_serial_in(dat_b),
    .i_aux_stereo_serial_in(aux), .i_bus_addr_strap_lo(strap[0]), .i_bus_addr_strap_hi(strap[1]),
    .o_serial_audio_out(sdo), .o_serial_audio_out_oe(oe), .o_primary_left(pl),
    .o_primary_right(pr), .o_primary_valid(pv), .o_aux_left(al), .o_aux_right(ar),
    .o_ref_tick(), .o_bus_slave_addr(), .o_amp_enable(amp));
  i2s_host_model #(.HALF(32)) i_host_a (.i_run(run_a), .i_left(hv[0]),
    .i_right(hv[1]), .i_aux(hv[2]), .i_sdo(sdo_w), .o_bck(bck_a), .o_ws(ws_a),
    .o_dat(dat_a), .o_aux_dat(aux), .o_rx(rx));
  i2s_host_model #(.HALF(16)) i_host_b (.i_run(run_b), .i_left(hv[3]),
    .i_right(hv[4]), .i_aux(hv[5]), .i_sdo(sdo_w), .o_bck(bck_b), .o_ws(ws_b),
    .o_dat(dat_b), .o_aux_dat(), .o_rx());
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    d = d_w;
  endtask
  task automatic wait_valid();
    int k;
    for (k = 0; pv !== 1'b1 && k < 3000; k++) @(negedge i_clk);
    if (k == 3000) fail_count++;
    repeat (2) @(posedge i_clk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #400000;
    fail_count++;
    conclude();
  end
  initial begin
    exp_w = '{24'hA5C3F1, 24'h3C5A0F, 24'h0F1E2D, 24'h5A0F3C};
    repeat (8) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(8'h00);
    `CHK("ctrl", 32'h0, d)
    rd(8'h28);
    `CHK("unmapped", 32'h0, d)
    wr(8'h08, 32'hFFA5C3F1);
    wr(8'h0C, 32'h003C5A0F);
    wr(8'h10, 32'h005A0F3C);
    rd(8'h08);
    `CHK("proc reg", 32'h00A5C3F1, d)
    $display("registers done");
    run_a <= 1'b1;
    wait_valid();
    `CHK("prim left", 24'h123456, pl)
    `CHK("prim right", 24'h654321, pr)
    `CHK("aux left", 24'h0F1E2D, al)
    `CHK("aux right", 24'h0F1E2D, ar)
    rd(8'h04);
    `CHK("status", 32'h00002A13, d)
    `CHK("oe off", 1'b0, oe)
    $display("port a done");
    for (int p = 0; p < 4; p++) begin
      wr(8'h00, 32'h2 | (p << 5));
      repeat (5) @(posedge ws_a);
      `CHK("payload", exp_w[p], rx)
    end
    `CHK("oe on", 1'b1, oe)
    wr(8'h00, 32'h6);
    repeat (5) @(posedge ws_a);
    `CHK("pass", 24'h091A2B, rx)
    $display("output done");
    run_a <= 1'b0;
    wr(8'h00, 32'h101);
    run_b <= 1'b1;
    wait_valid();
    `CHK("b left", 24'hBEEF00, pl)
    `CHK("b right", 24'hCAFE00, pr)
    `CHK("oe b off", 1'b0, oe)
    rd(8'h04);
    `CHK("ratio b", 3'h5, {d[5], d[3:2]})
    wr(8'h00, 32'h201);
    wr(8'h00, 32'h200);
    rd(8'h00);
    `CHK("choice kept", 32'h201, d)
    `CHK("amp", 1'b1, amp)
    @(posedge i_clk);
    i_rstn <= 1'b0;
    strap  <= 2'h1;
    repeat (8) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (6) @(posedge i_clk);
    rd(8'h04);
    `CHK("strap addr", 7'h29, d[14:8])
    $display("port b done");
    conclude();
  end
endmodule
